// ==== logic/wwd_pkg.sv ====
// Constants, types and register map of the window watchdog timing core.
// Function
// - Kick and mode inputs count as changed only after 3 to 4 stable ticks.
// - The wake pin counts as changed only after 96 to 128 stable ticks.
// - In the short disable and enable intervals, a kick low period longer than 45 ticks is a trigger error.
// - Changing from short to long supervision waits 1112 ticks.
// - Short mode opens with a 130 tick disable interval where no kick may come.
// - Short mode then opens a 124 tick enable interval that needs a kick.
// - Long mode runs a 71970 tick disable interval before its enable interval.
// - Long mode keeps a 30002 tick enable interval watching the wake pin.
// - A wake pin edge in the long enable interval gives a reset pulse.
// - A low mode level brings long supervision back to short supervision.
// - Every state change restarts the interval timer one cycle later.
// - A kick is accepted on the rising edge of the debounced kick level.
package wwd_pkg;

  localparam int unsigned TW = 17;

  // Interval lengths in oscillator ticks.
  localparam logic [TW-1:0] T_POWERUP   = 17'h000C9;
  localparam logic [TW-1:0] T_SWITCH    = 17'h00458;
  localparam logic [TW-1:0] T_SHORT_DIS = 17'h00082;
  localparam logic [TW-1:0] T_SHORT_EN  = 17'h0007C;
  localparam logic [TW-1:0] T_RESET_OUT = 17'h00028;
  localparam int unsigned   T_LONG_DIS  = 71970;
  localparam int unsigned   T_LONG_EN   = 30002;

  localparam logic [5:0] T_TRG_MAX  = 6'h2D;
  localparam logic [7:0] DEB_SHORT  = 8'h03;
  localparam logic [7:0] DEB_WAKE   = 8'h60;

  // Word indices of the registers; byte address is four times the index.
  localparam logic [2:0] ADR_CTRL     = 3'h0;
  localparam logic [2:0] ADR_STATUS   = 3'h1;
  localparam logic [2:0] ADR_IRQ_STAT = 3'h2;
  localparam logic [2:0] ADR_IRQ_CLR  = 3'h3;
  localparam logic [2:0] ADR_IRQ_EN   = 3'h4;

  localparam int unsigned CTRL_LONG_OK = 0;
  localparam logic [0:0]  CTRL_RST     = 1'h1;

  localparam int unsigned IRQ_EARLY = 0;
  localparam int unsigned IRQ_MISS  = 1;
  localparam int unsigned IRQ_TERR  = 2;
  localparam int unsigned IRQ_WAKE  = 3;
  localparam int unsigned IRQ_MODE  = 4;
  localparam int unsigned IRQ_W     = 5;

  typedef enum logic [2:0] {
    ST_POWERUP   = 3'b000,
    ST_SHORT_DIS = 3'b001,
    ST_SHORT_EN  = 3'b010,
    ST_SWITCH    = 3'b011,
    ST_LONG_DIS  = 3'b100,
    ST_LONG_EN   = 3'b101,
    ST_RESET     = 3'b110
  } state_t;

  typedef struct packed {
    logic       level;
    logic [7:0] cnt;
  } deb_t;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        wake;
    logic        mode;
    logic        kick;
    logic        rst_active;
    state_t      state;
  } status_t;

endpackage

// ==== logic/window_watchdog_timing.sv ====
// Window watchdog timing core with a classic Wishbone register slave.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// OSC_DIV sets how many clock cycles make one oscillator tick. The two long
// interval lengths are parameters so that a bench can shorten them; a real
// device keeps the defaults, since software relies on the sleep period.
module window_watchdog_timing #(
  parameter int unsigned OSC_DIV     = 1,
  parameter int unsigned LONG_DIS_CYC = wwd_pkg::T_LONG_DIS,
  parameter int unsigned LONG_EN_CYC  = wwd_pkg::T_LONG_EN
) (
  // Clock and power-on reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Microcontroller pins
  input  wire logic        kick_input,
  input  wire logic        mode_input,
  input  wire logic        wake_pin,
  output logic             mcu_reset_n,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // Everything that remembers lives in one struct, so the reset value and the
  // register stage are written once. The debounced levels, the edge history
  // and the supervision timer all move together on the same clock edge.
  typedef struct packed {
    wwd_pkg::state_t           state;
    logic                      chg;
    logic [wwd_pkg::TW-1:0]    timer;
    logic [15:0]               div;
    wwd_pkg::deb_t             kick;
    wwd_pkg::deb_t             mode;
    wwd_pkg::deb_t             wake;
    logic                      kick_prev;
    logic                      wake_prev;
    logic [5:0]                low_cnt;
    logic [0:0]                ctrl;
    logic [wwd_pkg::IRQ_W-1:0] irq_stat;
    logic [wwd_pkg::IRQ_W-1:0] irq_en;
    logic                      rst_n;
    logic                      irq;
    logic                      ack;
    logic [31:0]               dat;
  } core_t;

  core_t                     q;
  core_t                     d;
  logic                      tick;
  logic                      tmo;
  logic                      kick_ok;
  logic                      wake_edge;
  logic                      terr;
  logic                      mode_hi;
  logic                      acc;
  logic                      wr;
  logic [wwd_pkg::IRQ_W-1:0] set;
  logic [wwd_pkg::IRQ_W-1:0] clr;
  wwd_pkg::status_t          stat;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // A level is taken only after the raw input has differed for n ticks.
  // Any return to the held level restarts the count, so short glitches that
  // come and go between ticks never reach the state machine.
  function automatic wwd_pkg::deb_t deb_step(
    input logic          raw,
    input wwd_pkg::deb_t s,
    input logic [7:0]    n,
    input logic          en
  );
    wwd_pkg::deb_t r;
    r = s;
    if (raw == s.level) begin
      r.cnt = '0;
    end else if (en) begin
      if (s.cnt == n - 8'h01) begin
        r.level = raw;
        r.cnt   = '0;
      end else begin
        r.cnt = s.cnt + 8'h01;
      end
    end
    return r;
  endfunction

  // Length of the interval that each state waits for, in ticks. The illegal
  // code falls back to the reset pulse length, which is also where the state
  // machine recovers to.
  function automatic logic [wwd_pkg::TW-1:0] len_of(input wwd_pkg::state_t s);
    case (s)
      wwd_pkg::ST_POWERUP:   len_of = wwd_pkg::T_POWERUP;
      wwd_pkg::ST_SHORT_DIS: len_of = wwd_pkg::T_SHORT_DIS;
      wwd_pkg::ST_SHORT_EN:  len_of = wwd_pkg::T_SHORT_EN;
      wwd_pkg::ST_SWITCH:    len_of = wwd_pkg::T_SWITCH;
      wwd_pkg::ST_LONG_DIS:  len_of = wwd_pkg::TW'(LONG_DIS_CYC);
      wwd_pkg::ST_LONG_EN:   len_of = wwd_pkg::TW'(LONG_EN_CYC);
      wwd_pkg::ST_RESET:     len_of = wwd_pkg::T_RESET_OUT;
      default:               len_of = wwd_pkg::T_RESET_OUT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    d = q;
    set = '0;
    clr = '0;

    // Oscillator tick; every interval counts these.
    tick = (q.div == 16'(OSC_DIV - 1));
    d.div = tick ? '0 : q.div + 16'h0001;

    d.kick = deb_step(kick_input, q.kick, wwd_pkg::DEB_SHORT, tick);
    d.mode = deb_step(mode_input, q.mode, wwd_pkg::DEB_SHORT, tick);
    d.wake = deb_step(wake_pin, q.wake, wwd_pkg::DEB_WAKE, tick);
    d.kick_prev = q.kick.level;
    d.wake_prev = q.wake.level;

    kick_ok   = q.kick.level & ~q.kick_prev;
    wake_edge = q.wake.level ^ q.wake_prev;

    // The low counter saturates one past the limit, so an error fires once.
    terr = 1'b0;
    if (q.kick.level) begin
      d.low_cnt = '0;
    end else if (tick && (q.low_cnt != wwd_pkg::T_TRG_MAX + 6'h01)) begin
      d.low_cnt = q.low_cnt + 6'h01;
      terr = (q.low_cnt == wwd_pkg::T_TRG_MAX);
    end

    mode_hi = q.mode.level & q.ctrl[wwd_pkg::CTRL_LONG_OK];

    // A timeout may still hit in the cycle after a pin-driven change, since
    // the timer is only cleared then; that gives the documented double step.
    tmo = tick && (q.timer == len_of(q.state) - 17'h00001);

    // Pin events take priority over the timer in every state but ST_POWERUP and ST_RESET, which only time out: a trigger error
    // beats a kick, a kick beats a mode change, and a mode change beats the
    // timeout. A microcontroller that misbehaves is therefore always punished
    // before the window can close normally.
    case (q.state)
      wwd_pkg::ST_POWERUP: begin
        if (tmo) begin
          d.state = wwd_pkg::ST_SHORT_DIS;
        end
      end
      wwd_pkg::ST_SHORT_DIS: begin
        if (terr) begin
          d.state = wwd_pkg::ST_RESET;
          set[wwd_pkg::IRQ_TERR] = 1'b1;
        end else if (kick_ok) begin
          d.state = wwd_pkg::ST_RESET;
          set[wwd_pkg::IRQ_EARLY] = 1'b1;
        end else if (mode_hi) begin
          d.state = wwd_pkg::ST_SWITCH;
          set[wwd_pkg::IRQ_MODE] = 1'b1;
        end else if (tmo) begin
          d.state = wwd_pkg::ST_SHORT_EN;
        end
      end
      wwd_pkg::ST_SHORT_EN: begin
        if (terr) begin
          d.state = wwd_pkg::ST_RESET;
          set[wwd_pkg::IRQ_TERR] = 1'b1;
        end else if (kick_ok) begin
          d.state = wwd_pkg::ST_SHORT_DIS;
        end else if (mode_hi) begin
          d.state = wwd_pkg::ST_SWITCH;
          set[wwd_pkg::IRQ_MODE] = 1'b1;
        end else if (tmo) begin
          d.state = wwd_pkg::ST_RESET;
          set[wwd_pkg::IRQ_MISS] = 1'b1;
        end
      end
      wwd_pkg::ST_SWITCH: begin
        if (!mode_hi) begin
          d.state = wwd_pkg::ST_SHORT_DIS;
          set[wwd_pkg::IRQ_MODE] = 1'b1;
        end else if (tmo) begin
          d.state = wwd_pkg::ST_LONG_DIS;
        end
      end
      wwd_pkg::ST_LONG_DIS: begin
        if (!mode_hi) begin
          d.state = wwd_pkg::ST_SHORT_DIS;
          set[wwd_pkg::IRQ_MODE] = 1'b1;
        end else if (tmo) begin
          d.state = wwd_pkg::ST_LONG_EN;
        end
      end
      wwd_pkg::ST_LONG_EN: begin
        if (!mode_hi) begin
          d.state = wwd_pkg::ST_SHORT_DIS;
          set[wwd_pkg::IRQ_MODE] = 1'b1;
        end else if (wake_edge) begin
          d.state = wwd_pkg::ST_RESET;
          set[wwd_pkg::IRQ_WAKE] = 1'b1;
        end else if (tmo) begin
          // Cyclic wake-up of the sleeping microcontroller.
          d.state = wwd_pkg::ST_RESET;
          set[wwd_pkg::IRQ_WAKE] = 1'b1;
        end
      end
      wwd_pkg::ST_RESET: begin
        if (tmo) begin
          d.state = wwd_pkg::ST_SHORT_DIS;
        end
      end
      default: begin
        d.state = wwd_pkg::ST_RESET;
      end
    endcase

    d.chg = (d.state != q.state);
    if (q.chg) begin
      d.timer = '0;
    end else if (tick && (q.timer != '1)) begin
      d.timer = q.timer + 17'h00001;
    end

    d.rst_n = !((d.state == wwd_pkg::ST_POWERUP) || (d.state == wwd_pkg::ST_RESET));

    // Wishbone slave: ack one cycle after the strobe, dropped the next.
    // The ack gate keeps a held strobe from being taken in two cycles in a row; a master that
    // keeps cyc and stb up after the ack simply gets a second transfer one
    // cycle later. Only byte lane 0 carries writable fields.
    acc = wb_cyc_i & wb_stb_i & ~q.ack;
    wr  = acc & wb_we_i & wb_sel_i[0];
    d.ack = acc;

    stat = '0;
    stat.wake = q.wake.level;
    stat.mode = q.mode.level;
    stat.kick = q.kick.level;
    stat.rst_active = ~q.rst_n;
    stat.state = q.state;

    if (wr) begin
      case (wb_adr_i[4:2])
        wwd_pkg::ADR_CTRL:    d.ctrl = wb_dat_i[0:0];
        wwd_pkg::ADR_IRQ_CLR: clr = wb_dat_i[wwd_pkg::IRQ_W-1:0];
        wwd_pkg::ADR_IRQ_EN:  d.irq_en = wb_dat_i[wwd_pkg::IRQ_W-1:0];
        default:              d.ctrl = q.ctrl;
      endcase
    end

    if (acc) begin
      case (wb_adr_i[4:2])
        wwd_pkg::ADR_CTRL:     d.dat = 32'(q.ctrl);
        wwd_pkg::ADR_STATUS:   d.dat = stat;
        wwd_pkg::ADR_IRQ_STAT: d.dat = 32'(q.irq_stat);
        wwd_pkg::ADR_IRQ_EN:   d.dat = 32'(q.irq_en);
        default:               d.dat = '0;
      endcase
    end

    // An event in the clearing cycle survives the clear.
    d.irq_stat = (q.irq_stat & ~clr) | set;
    d.irq = |(d.irq_stat & d.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // The kick pin idles high on its pull-up, so its debouncer and edge history
  // start high; otherwise the first ticks after reset would look like a kick.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.ctrl <= wwd_pkg::CTRL_RST;
      q.kick.level <= 1'b1;
      q.kick_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Every output is a register bit, so no decode glitch reaches the pins.
  assign mcu_reset_n = q.rst_n;
  assign irq         = q.irq;
  assign wb_ack_o    = q.ack;
  assign wb_dat_o    = q.dat;

endmodule

// ==== verif/wwd_chk.sv ====
// Port-level assertions for the window watchdog timing core.
`timescale 1ns/1ps

module wwd_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins
  input wire logic kick_input,
  input wire logic mode_input,
  input wire logic wake_pin,
  input wire logic mcu_reset_n
);
  logic [8:0] low_q;
  logic [8:0] idle_q;
  logic [6:0] klow_q;

  // The kick pin counters only run while the core should be in short supervision.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      low_q  <= 9'h000;
      idle_q <= 9'h000;
      klow_q <= 7'h00;
    end else begin
      low_q  <= mcu_reset_n ? 9'h000 : low_q + 9'h001;
      klow_q <= (kick_input | mode_input | ~mcu_reset_n) ? 7'h00 : klow_q + 7'h01;
      idle_q <= (mode_input | ~mcu_reset_n | $changed(kick_input)) ? 9'h000 : idle_q + 9'h001;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  AST_RST_HOLD: assert property ($fell(mcu_reset_n) |=> !mcu_reset_n [*8])
    else $error("reset pulse too short");
  AST_RST_LEN: assert property ($rose(mcu_reset_n) |-> low_q inside {[40:44], [201:206]})
    else $error("reset low length wrong");
  AST_TRG_ERR: assert property (klow_q <= 7'h38)
    else $error("long kick low not punished");
  AST_MISS: assert property (idle_q <= 9'h10E)
    else $error("missing kick not punished");
  AST_KICK_DEB: assert property ($rose(kick_input) && mcu_reset_n |=> mcu_reset_n [*3])
    else $error("kick acted before debounce");
  AST_WAKE_DEB: assert property ($changed(wake_pin) && mcu_reset_n |=> mcu_reset_n [*8])
    else $error("wake acted before debounce");
endmodule

bind window_watchdog_timing wwd_chk chk (
  .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .kick_input(kick_input), .mode_input(mode_input),
  .wake_pin(wake_pin), .mcu_reset_n(mcu_reset_n)
);

// ==== verif/mcu_model.sv ====
// Behavioural microcontroller driving the kick, mode and wake pins.
`timescale 1ns/1ps

module mcu_model (
  // Clock
  input wire logic ref_clk,
  // Pins towards the core
  output logic     kick_input,
  output logic     mode_input,
  output logic     wake_pin
);
  // Idle levels follow the pull-up on kick and the pull-down on wake.
  initial begin
    kick_input = 1'b1;
    mode_input = 1'b0;
    wake_pin   = 1'b0;
  end

  // A kick is a low period and then the rising edge; keep low under 45 ticks.
  task automatic kick(input int low);
    @(posedge ref_clk);
    kick_input <= 1'b0;
    repeat (low) @(posedge ref_clk);
    kick_input <= 1'b1;
  endtask

  task automatic set_mode(input logic m);
    @(posedge ref_clk);
    mode_input <= m;
  endtask

  task automatic toggle_wake;
    @(posedge ref_clk);
    wake_pin <= ~wake_pin;
  endtask
endmodule

// ==== verif/window_watchdog_timing_tb.sv ====
// Self-checking bench for the window watchdog timing core.
`timescale 1ns/1ps

module window_watchdog_timing_tb;
  logic        ref_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  sel      = 4'hF;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic        wb_ack_o;
  logic        kick_input;
  logic        mode_input;
  logic        wake_pin;
  logic        mcu_reset_n;
  logic        irq;
  int          fails    = 0;
  int          checked  = 0;
  int          len;

  always #5 ref_clk = ~ref_clk;

  mcu_model mcu (.ref_clk(ref_clk), .kick_input(kick_input), .mode_input(mode_input),
                 .wake_pin(wake_pin));

  // Long intervals shortened so the sleep path fits in the run.
  window_watchdog_timing #(.LONG_DIS_CYC(300), .LONG_EN_CYC(300)) uut (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .kick_input(kick_input),
    .mode_input(mode_input), .wake_pin(wake_pin), .mcu_reset_n(mcu_reset_n), .irq(irq));

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    repeat (20) begin
      @(posedge ref_clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (wb_ack_o !== 1'b1) fails++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Waits a bounded time for a reset pulse and measures its low length.
  task automatic wait_rst(input int max);
    len = 0;
    repeat (max) begin
      @(posedge ref_clk);
      if (mcu_reset_n === 1'b0) break;
    end
    while (mcu_reset_n === 1'b0 && len < 300) begin
      @(posedge ref_clk);
      len++;
    end
  endtask

  task automatic stat_clr(input logic [31:0] exp);
    wb(1'b0, 5'h08, 32'h0);
    chk("irq_stat", rd, exp);
    chk("irq", irq, 1'b1);
    wb(1'b1, 5'h0C, 32'h1F);
    wb(1'b0, 5'h08, 32'h0);
    chk("irq_stat cleared", rd, 32'h0);
    chk("irq low", irq, 1'b0);
  endtask

  ////////////////////////////////////////
  task automatic t_powerup;
    wait_rst(2);
    chk("powerup length", len >= 201 && len <= 206, 1'b1);
    $display("test powerup done");
  endtask

  task automatic t_regs;
    wb(1'b0, 5'h00, 32'h0);
    chk("ctrl", rd, 32'h1);
    wb(1'b0, 5'h10, 32'h0);
    chk("irq_en", rd, 32'h0);
    wb(1'b0, 5'h14, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, 5'h10, 32'h1F);
    wb(1'b0, 5'h10, 32'h0);
    chk("irq_en", rd, 32'h1F);
    sel = 4'h0;
    wb(1'b1, 5'h10, 32'h0);
    sel = 4'hF;
    wb(1'b0, 5'h10, 32'h0);
    chk("irq_en lane off", rd, 32'h1F);
    $display("test regs done");
  endtask

  task automatic t_kick;
    repeat (3) begin
      repeat (150) @(posedge ref_clk);
      mcu.kick(8);
    end
    wait_rst(100);
    chk("no reset", len, 0);
    $display("test kick done");
  endtask

  // The previous kick restarted the disable interval, so this one is early.
  task automatic t_early;
    mcu.kick(8);
    wait_rst(40);
    chk("early reset length", len >= 40 && len <= 45, 1'b1);
    stat_clr(32'h1);
    $display("test early done");
  endtask

  task automatic t_miss;
    wait_rst(400);
    chk("miss reset length", len >= 40 && len <= 45, 1'b1);
    stat_clr(32'h2);
    $display("test miss done");
  endtask

  task automatic t_terr;
    fork
      mcu.kick(60);
      wait_rst(120);
    join
    chk("error reset length", len >= 40 && len <= 45, 1'b1);
    stat_clr(32'h4);
    $display("test trigger error done");
  endtask

  task automatic t_long;
    mcu.set_mode(1'b1);
    repeat (1100) @(posedge ref_clk);
    wb(1'b0, 5'h04, 32'h0);
    chk("state switch", rd[2:0], 3'h3);
    repeat (100) @(posedge ref_clk);
    wb(1'b0, 5'h04, 32'h0);
    chk("state long dis", rd[2:0], 3'h4);
    repeat (250) @(posedge ref_clk);
    wb(1'b0, 5'h04, 32'h0);
    chk("state long en", rd[2:0], 3'h5);
    mcu.toggle_wake;
    wait_rst(90);
    chk("wake too soon", len, 0);
    wait_rst(100);
    chk("wake reset length", len >= 40 && len <= 45, 1'b1);
    stat_clr(32'h18);
    $display("test long done");
  endtask

  task automatic t_mode_back;
    repeat (20) @(posedge ref_clk);
    mcu.set_mode(1'b0);
    repeat (10) @(posedge ref_clk);
    wb(1'b0, 5'h04, 32'h0);
    chk("state short", rd[2:0], 3'h1);
    $display("test mode back done");
  endtask

  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_powerup;
    t_regs;
    t_kick;
    t_early;
    t_miss;
    t_terr;
    t_long;
    t_mode_back;
    wrap_up;
  end

  // The whole sequence needs about 3000 cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    wrap_up;
  end
endmodule
